/* File: pkg/pwq_pkg.sv */
package pwq_pkg;

  // ****************************************
  // register offsets within a port page
  // ****************************************
  localparam logic [11:0] OFS_PM_CTRL1 = 12'h834;
  localparam logic [11:0] OFS_Q_THR    = 12'h840;
  localparam logic [11:0] OFS_Q_MULT   = 12'h844;
  localparam logic [11:0] OFS_Q_MON    = 12'h848;
  localparam logic [11:0] OFS_TXQ_SEL  = 12'h900;
  localparam logic [11:0] OFS_VID_REP  = 12'h904;

  // ****************************************
  // field layout
  // ****************************************
  localparam int          FLD_W        = 11;
  localparam int          HI_LSB       = 16;
  localparam int          LO_LSB       = 0;
  localparam int          CNT_W        = 24;
  localparam int          QSEL_W       = 2;
  localparam int          NUM_Q        = 4;
  localparam int          NUM_TYPE     = 4;
  localparam int          VID_W        = 12;
  localparam int          MON_LSB      = 26;
  localparam int          MON_W        = 6;
  // bit positions inside the 6-bit monitor control slice
  localparam int          MON_RAND     = 5;
  localparam int          MON_FLUSH    = 4;
  localparam int          MON_ALL      = 3;
  localparam int          MON_YR       = 2;
  localparam int          MON_R        = 1;
  localparam int          MON_DROPALL  = 0;
  localparam int          PROB_SHIFT   = 7;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [10:0] RST_Q_MAX    = 11'h080;
  localparam logic [10:0] RST_Q_MIN    = 11'h009;
  localparam logic [10:0] RST_Q_MULT   = 11'h010;
  localparam logic [10:0] RST_PM_MULT  = 11'h020;
  localparam logic [10:0] LFSR_SEED    = 11'h001;
  localparam logic [10:0] LFSR_TAPS    = 11'h500;

  // ****************************************
  // packet colours and monitor types
  // ****************************************
  localparam logic [1:0]  COL_GREEN    = 2'h0;
  localparam logic [1:0]  COL_YELLOW   = 2'h1;
  localparam logic [1:0]  COL_RED      = 2'h2;
  localparam logic [1:0]  TYP_DROPPED  = 2'h0;

endpackage

/* File: hdl/pwq_drop_decide.sv */
`timescale 1ns/10ps
`default_nettype none
module pwq_drop_decide
  import pwq_pkg::*;
(
  // clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  // packet under test
  input  wire logic             pkt_valid_in,
  input  wire logic [1:0]       pkt_colour_in,
  input  wire logic [FLD_W-1:0] avg_in,
  input  wire logic [FLD_W-1:0] pm_avg_in,
  // settings of that packet's queue and of its port
  input  wire logic             police_en_in,
  input  wire logic [MON_W-1:0] mon_in,
  input  wire logic [FLD_W-1:0] min_in,
  input  wire logic [FLD_W-1:0] max_in,
  input  wire logic [FLD_W-1:0] mult_in,
  input  wire logic [FLD_W-1:0] pm_mult_in,
  // verdict
  output logic                  drop_out,
  output logic                  drop_valid_out
);

  logic [FLD_W-1:0]   lfsr;
  logic [2*FLD_W-1:0] q_prod;
  logic [2*FLD_W-1:0] pm_prod;
  logic [FLD_W-1:0]   span;
  logic               inhibit;
  logic               next_drop;

  // ****************************************
  // pseudo random source
  // ****************************************
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lfsr <= LFSR_SEED;
    end else begin
      lfsr <= lfsr[0] ? ((lfsr >> 1) ^ LFSR_TAPS) : (lfsr >> 1);
    end
  end

  // ****************************************
  // decision
  // ****************************************
  always_comb begin
    inhibit = mon_in[MON_ALL]
      || (mon_in[MON_YR] && pkt_colour_in != COL_GREEN)
      || (mon_in[MON_R] && pkt_colour_in == COL_RED);
    span    = (avg_in > max_in) ? (max_in - min_in) : (avg_in - min_in);
    q_prod  = span * mult_in;
    pm_prod = pm_avg_in * pm_mult_in;
    if (!police_en_in || !mon_in[MON_RAND] || inhibit) begin
      next_drop = 1'b0;
    end else if (avg_in < min_in) begin
      next_drop = 1'b0;
    end else if (avg_in > max_in && mon_in[MON_DROPALL]) begin
      next_drop = 1'b1;
    end else begin
      next_drop = (q_prod[PROB_SHIFT +: FLD_W] > lfsr)
        || (pm_prod[PROB_SHIFT +: FLD_W] > lfsr);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      drop_out       <= 1'b0;
      drop_valid_out <= 1'b0;
    end else begin
      drop_out       <= pkt_valid_in & next_drop;
      drop_valid_out <= pkt_valid_in;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_rand_off;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (pkt_valid_in && !mon_in[MON_RAND]) |=> !drop_out;
  endproperty
  a_rand_off: assert property (p_rand_off)
    else $error("drop while random drop disabled");

  property p_all_inhibit;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (pkt_valid_in && mon_in[MON_ALL]) |=> !drop_out;
  endproperty
  a_all_inhibit: assert property (p_all_inhibit)
    else $error("drop while all colours inhibited");

  property p_yr_inhibit;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (pkt_valid_in && mon_in[MON_YR] && pkt_colour_in != COL_GREEN)
      |=> !drop_out;
  endproperty
  a_yr_inhibit: assert property (p_yr_inhibit)
    else $error("yellow or red drop while inhibited");

  property p_r_inhibit;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (pkt_valid_in && mon_in[MON_R] && pkt_colour_in == COL_RED)
      |=> !drop_out;
  endproperty
  a_r_inhibit: assert property (p_r_inhibit)
    else $error("red drop while inhibited");

  property p_drop_all;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (pkt_valid_in && police_en_in && avg_in > max_in && mon_in == 6'h21)
      |=> drop_out;
  endproperty
  a_drop_all: assert property (p_drop_all)
    else $error("drop-all above max threshold did not drop");

  property p_below_min;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (pkt_valid_in && avg_in < min_in) |=> !drop_out;
  endproperty
  a_below_min: assert property (p_below_min)
    else $error("drop below min threshold");

  property p_police_off;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (pkt_valid_in && !police_en_in) |=> (drop_valid_out && !drop_out);
  endproperty
  a_police_off: assert property (p_police_off)
    else $error("drop while policing disabled");

endmodule
`default_nettype wire

/* File: hdl/pwq_event_counters.sv */
`timescale 1ns/10ps
`default_nettype none
module pwq_event_counters
  import pwq_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              rst_n_in,
  // packet events
  input  wire logic              ev_valid_in,
  input  wire logic [QSEL_W-1:0] ev_queue_in,
  input  wire logic [1:0]        ev_colour_in,
  input  wire logic              ev_dropped_in,
  // control
  input  wire logic [NUM_Q-1:0]  flush_in,
  input  wire logic [QSEL_W-1:0] sel_queue_in,
  input  wire logic [1:0]        sel_type_in,
  // readback
  output logic [CNT_W-1:0]       count_out
);

  logic [CNT_W-1:0] cnt [NUM_Q*NUM_TYPE];

  // ****************************************
  // one counter per queue and type
  // ****************************************
  for (genvar g = 0; g < NUM_Q*NUM_TYPE; g++) begin : g_cnt
    localparam logic [1:0] Q = 2'(g / NUM_TYPE);
    localparam logic [1:0] T = 2'(g % NUM_TYPE);
    logic hit;
    assign hit = ev_valid_in && ev_queue_in == Q
      && ((T == TYP_DROPPED) ? ev_dropped_in : (ev_colour_in == 2'(T - 2'h1)));
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        cnt[g] <= '0;
      end else if (flush_in[Q]) begin
        cnt[g] <= hit ? CNT_W'(1) : '0;
      end else if (hit) begin
        cnt[g] <= cnt[g] + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_out <= '0;
    end else begin
      count_out <= cnt[{sel_queue_in, sel_type_in}];
    end
  end

  property p_flush_clears;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (flush_in[0] && !(ev_valid_in && ev_queue_in == 2'h0))
      |=> (cnt[0] == '0 && cnt[1] == '0 && cnt[2] == '0 && cnt[3] == '0);
  endproperty
  a_flush_clears: assert property (p_flush_clears)
    else $error("queue 0 counters not cleared by flush");

endmodule
`default_nettype wire

/* File: hdl/pwq_regs_top.sv */
`timescale 1ns/10ps
`default_nettype none
// Function
// - random dropping on a queue only while its random drop enable is set
// - rising edge of the flush bit clears all monitor counters of the queue; a counter with an event in the flush cycle restarts at 1
// - all-colour inhibit set means no packet of any colour is dropped
// - yellow-red inhibit set means yellow and red packets are never dropped
// - red inhibit set means red packets are never dropped
// - drop-all drops every uninhibited packet above max threshold, else the queue and packet-memory multipliers decide
// - read-only 24-bit event count of selected queue in monitor register low bits
// - 11-bit max threshold per queue, reset 0x080, reached via queue selector
// - 11-bit min threshold per queue, reset 0x009, reached via queue selector
// - 11-bit per-queue probability multiplier, reset 0x010
// - average size of selected queue readable in low bits of multiplier register
// - 11-bit packet-memory probability multiplier per port, reset 0x020
// - average packet-memory occupancy readable in low bits of its register
// - software writes the queue selector first; queue accesses then go there
// - queue selector writable as one byte at the word's highest byte address
// - substitution on replaces any non-zero egress VLAN ID by port default ID
// - with double tagging the outer service tag ID is the one replaced
// - dropping only happens while the port policing enable is set
// - 2-bit type picks dropped, green, yellow or red for the counter readback
module pwq_regs_top
  import pwq_pkg::*;
#(
  parameter logic [3:0] PORT_NUM = 4'h1
)(
  // clock and reset
  input  wire logic                  clk_sys_in,
  input  wire logic                  rstn_in,
  // management register port
  input  wire logic [15:0]           reg_addr_in,
  input  wire logic [3:0]            reg_byte_en_in,
  input  wire logic                  reg_wr_in,
  input  wire logic                  reg_rd_in,
  input  wire logic [31:0]           reg_wdata_in,
  output logic [31:0]                reg_rdata_out,
  output logic                       reg_rvalid_out,
  // port settings held elsewhere
  input  wire logic                  policing_enable_in,
  input  wire logic [1:0]            monitor_packet_type_in,
  // occupancy from the queue manager
  input  wire logic [NUM_Q*FLD_W-1:0] queue_avg_in,
  input  wire logic [FLD_W-1:0]      pm_avg_in,
  // packet drop check
  input  wire logic                  pkt_valid_in,
  input  wire logic [QSEL_W-1:0]     pkt_queue_in,
  input  wire logic [1:0]            pkt_colour_in,
  output logic                       drop_out,
  output logic                       drop_valid_out,
  // egress tag rewrite
  input  wire logic                  egress_valid_in,
  input  wire logic                  double_tag_in,
  input  wire logic [VID_W-1:0]      port_default_vlan_id_in,
  input  wire logic [VID_W-1:0]      inner_vid_in,
  input  wire logic [VID_W-1:0]      outer_vid_in,
  output logic                       egress_valid_out,
  output logic [VID_W-1:0]           inner_vid_out,
  output logic [VID_W-1:0]           outer_vid_out
);

  logic              rst_meta;
  logic              rst_n;
  logic [FLD_W-1:0]  q_max [NUM_Q];
  logic [FLD_W-1:0]  q_min [NUM_Q];
  logic [FLD_W-1:0]  q_mult [NUM_Q];
  logic [MON_W-1:0]  q_mon [NUM_Q];
  logic [FLD_W-1:0]  pm_mult;
  logic [QSEL_W-1:0] txq_sel;
  logic              egress_vlan_id_substitution;
  logic [NUM_Q-1:0]  flush_pulse;
  logic [CNT_W-1:0]  event_count;
  logic [FLD_W-1:0]  sel_avg;
  logic [FLD_W-1:0]  pkt_avg;
  logic              port_hit;
  logic [11:0]       word_ofs;
  logic [31:0]       cur_word;
  logic [31:0]       lane_mask;
  logic [31:0]       merged;
  logic              wr_hit;
  logic              flush_rise;

  // ****************************************
  // reset release
  // ****************************************
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************
  // address decode and read mux
  // ****************************************
  assign port_hit = reg_addr_in[15:12] == PORT_NUM;
  assign word_ofs = {reg_addr_in[11:2], 2'b00};
  assign wr_hit   = reg_wr_in & port_hit;
  assign sel_avg  = queue_avg_in[txq_sel*FLD_W +: FLD_W];
  assign pkt_avg  = queue_avg_in[pkt_queue_in*FLD_W +: FLD_W];

  always_comb begin
    cur_word = '0;
    unique case (word_ofs)
      OFS_PM_CTRL1: begin
        cur_word[HI_LSB +: FLD_W] = pm_mult;
        cur_word[LO_LSB +: FLD_W] = pm_avg_in;
      end
      OFS_Q_THR: begin
        cur_word[HI_LSB +: FLD_W] = q_max[txq_sel];
        cur_word[LO_LSB +: FLD_W] = q_min[txq_sel];
      end
      OFS_Q_MULT: begin
        cur_word[HI_LSB +: FLD_W] = q_mult[txq_sel];
        cur_word[LO_LSB +: FLD_W] = sel_avg;
      end
      OFS_Q_MON: begin
        cur_word[MON_LSB +: MON_W] = q_mon[txq_sel];
        cur_word[CNT_W-1:0]        = event_count;
      end
      OFS_TXQ_SEL: cur_word[QSEL_W-1:0] = txq_sel;
      OFS_VID_REP: cur_word[0] = egress_vlan_id_substitution;
      default: cur_word = '0;
    endcase
  end

  // byte lane 3 is the highest byte address and carries bits 7:0
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane_mask[31-8*i -: 8] = {8{reg_byte_en_in[i]}};
    end
  end
  assign merged     = (cur_word & ~lane_mask) | (reg_wdata_in & lane_mask);
  assign flush_rise = wr_hit && word_ofs == OFS_Q_MON
    && !q_mon[txq_sel][MON_FLUSH] && merged[MON_LSB + MON_FLUSH];

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_out  <= '0;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rdata_out  <= (reg_rd_in && port_hit) ? cur_word : '0;
      reg_rvalid_out <= reg_rd_in;
    end
  end

  // ****************************************
  // queue selector and port registers
  // ****************************************
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      txq_sel <= '0;
    end else if (wr_hit && word_ofs == OFS_TXQ_SEL) begin
      txq_sel <= merged[QSEL_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      pm_mult                     <= RST_PM_MULT;
      egress_vlan_id_substitution <= 1'b0;
    end else if (wr_hit) begin
      if (word_ofs == OFS_PM_CTRL1) begin
        pm_mult <= merged[HI_LSB +: FLD_W];
      end
      if (word_ofs == OFS_VID_REP) begin
        egress_vlan_id_substitution <= merged[0];
      end
    end
  end

  // ****************************************
  // per-queue registers
  // ****************************************
  for (genvar q = 0; q < NUM_Q; q++) begin : g_queue
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
        q_max[q]  <= RST_Q_MAX;
        q_min[q]  <= RST_Q_MIN;
        q_mult[q] <= RST_Q_MULT;
        q_mon[q]  <= '0;
      end else if (wr_hit && txq_sel == QSEL_W'(q)) begin
        if (word_ofs == OFS_Q_THR) begin
          q_max[q] <= merged[HI_LSB +: FLD_W];
          q_min[q] <= merged[LO_LSB +: FLD_W];
        end
        if (word_ofs == OFS_Q_MULT) begin
          q_mult[q] <= merged[HI_LSB +: FLD_W];
        end
        if (word_ofs == OFS_Q_MON) begin
          q_mon[q] <= merged[MON_LSB +: MON_W];
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      flush_pulse <= '0;
    end else begin
      flush_pulse <= flush_rise ? (NUM_Q'(1) << txq_sel) : '0;
    end
  end

  // ****************************************
  // drop decision and monitor counters
  // ****************************************
  pwq_drop_decide u_drop (
    .clk_sys_in     (clk_sys_in),
    .rst_n_in       (rst_n),
    .pkt_valid_in   (pkt_valid_in),
    .pkt_colour_in  (pkt_colour_in),
    .avg_in         (pkt_avg),
    .pm_avg_in      (pm_avg_in),
    .police_en_in   (policing_enable_in),
    .mon_in         (q_mon[pkt_queue_in]),
    .min_in         (q_min[pkt_queue_in]),
    .max_in         (q_max[pkt_queue_in]),
    .mult_in        (q_mult[pkt_queue_in]),
    .pm_mult_in     (pm_mult),
    .drop_out       (drop_out),
    .drop_valid_out (drop_valid_out)
  );

  logic [QSEL_W-1:0] ev_queue;
  logic [1:0]        ev_colour;

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      ev_queue  <= '0;
      ev_colour <= COL_GREEN;
    end else if (pkt_valid_in) begin
      ev_queue  <= pkt_queue_in;
      ev_colour <= pkt_colour_in;
    end
  end

  pwq_event_counters u_cnt (
    .clk_sys_in    (clk_sys_in),
    .rst_n_in      (rst_n),
    .ev_valid_in   (drop_valid_out & policing_enable_in),
    .ev_queue_in   (ev_queue),
    .ev_colour_in  (ev_colour),
    .ev_dropped_in (drop_out),
    .flush_in      (flush_pulse),
    .sel_queue_in  (txq_sel),
    .sel_type_in   (monitor_packet_type_in),
    .count_out     (event_count)
  );

  // ****************************************
  // egress tag rewrite
  // ****************************************
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      egress_valid_out <= 1'b0;
      inner_vid_out    <= '0;
      outer_vid_out    <= '0;
    end else begin
      egress_valid_out <= egress_valid_in;
      inner_vid_out    <= inner_vid_in;
      outer_vid_out    <= outer_vid_in;
      if (egress_vlan_id_substitution && double_tag_in && outer_vid_in != '0) begin
        outer_vid_out <= port_default_vlan_id_in;
      end
      if (egress_vlan_id_substitution && !double_tag_in && inner_vid_in != '0) begin
        inner_vid_out <= port_default_vlan_id_in;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_sel_byte;
    @(posedge clk_sys_in) disable iff (!rst_n)
      (wr_hit && word_ofs == OFS_TXQ_SEL && reg_byte_en_in == 4'h8)
      |=> txq_sel == $past(reg_wdata_in[QSEL_W-1:0]);
  endproperty
  a_sel_byte: assert property (p_sel_byte)
    else $error("byte write to queue selector lost");

  property p_thr_write;
    @(posedge clk_sys_in) disable iff (!rst_n)
      (wr_hit && word_ofs == OFS_Q_THR && reg_byte_en_in == 4'hf)
      |=> q_max[$past(txq_sel)] == $past(reg_wdata_in[HI_LSB +: FLD_W]);
  endproperty
  a_thr_write: assert property (p_thr_write)
    else $error("max threshold not written to selected queue");

  property p_other_port;
    @(posedge clk_sys_in) disable iff (!rst_n)
      (reg_wr_in && !port_hit) |=> ($stable(txq_sel) && $stable(pm_mult));
  endproperty
  a_other_port: assert property (p_other_port)
    else $error("write for another port changed registers");

  property p_vid_sub;
    @(posedge clk_sys_in) disable iff (!rst_n)
      (egress_vlan_id_substitution && !double_tag_in && inner_vid_in != '0)
      |=> inner_vid_out == $past(port_default_vlan_id_in);
  endproperty
  a_vid_sub: assert property (p_vid_sub)
    else $error("inner VLAN ID not substituted");

endmodule
`default_nettype wire

/* File: testbench/pwq_regs_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic        clk  = 1'b0;
  logic        rstn = 1'b0;
  logic        wr   = 1'b0;
  logic        rd   = 1'b0;
  logic        pol  = 1'b0;
  logic        pv   = 1'b0;
  logic        ev   = 1'b0;
  logic        dbl  = 1'b0;
  logic [15:0] ad   = 16'h0;
  logic [3:0]  be   = 4'hf;
  logic [31:0] wd   = 32'h0;
  logic [1:0]  ty   = 2'h0;
  logic [1:0]  col  = 2'h0;
  logic [10:0] av0  = 11'h0;
  logic [11:0] pdv  = 12'h5a5;
  logic [11:0] iv   = 12'h0;
  logic [11:0] ov   = 12'h0;
  logic [31:0] rdat;
  logic [11:0] io;
  logic [11:0] oo;
  logic        rv;
  logic        dr;
  logic        dv;
  logic        evo;
  int          miscompares = 0;
  int          n_checks    = 0;
  // drop table: monitor control byte, colours two bits each, expected verdicts
  logic [7:0]  tm [12] = '{8'h84, 8'h84, 8'h84, 8'h8c, 8'h8c, 8'h94,
                           8'h94, 8'h94, 8'ha4, 8'h84, 8'h00, 8'h84};
  logic [23:0] tc = 24'h4124a4;
  logic [11:0] te = 12'h897;

  pwq_regs_top #(.PORT_NUM(4'h1)) i_dut (
    .clk_sys_in(clk), .rstn_in(rstn),
    .reg_addr_in(ad), .reg_byte_en_in(be), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_wdata_in(wd), .reg_rdata_out(rdat), .reg_rvalid_out(rv),
    .policing_enable_in(pol), .monitor_packet_type_in(ty),
    .queue_avg_in({11'h333, 11'h222, 11'h111, av0}), .pm_avg_in(11'h155),
    .pkt_valid_in(pv), .pkt_queue_in(2'h0), .pkt_colour_in(col),
    .drop_out(dr), .drop_valid_out(dv),
    .egress_valid_in(ev), .double_tag_in(dbl), .port_default_vlan_id_in(pdv),
    .inner_vid_in(iv), .outer_vid_in(ov), .egress_valid_out(evo),
    .inner_vid_out(io), .outer_vid_out(oo));

  initial forever #4 clk = ~clk;

  // ****************************************
  // shared tasks
  // ****************************************
  function automatic logic [31:0] w(input logic [10:0] h, input logic [10:0] l);
    return {5'h0, h, 5'h0, l};
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrr(input logic [15:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge clk) #1 ad = a;
    be = b;
    wd = d;
    wr = 1'b1;
    @(posedge clk) #1 wr = 1'b0;
  endtask

  task automatic rdc(input logic [15:0] a, input logic [31:0] e);
    @(posedge clk) #1 ad = a;
    rd = 1'b1;
    @(posedge clk) #1 rd = 1'b0;
    check("rvalid", {31'h0, rv}, 32'h1);
    check($sformatf("rdata %h", a), rdat, e);
  endtask

  task automatic judge(input logic [1:0] c, input logic e);
    @(posedge clk) #1 col = c;
    pv = 1'b1;
    @(posedge clk) #1 pv = 1'b0;
    check("drop", {30'h0, dv, dr}, {30'h0, 1'b1, e});
  endtask

  task automatic egr(input logic d, input logic [11:0] i, input logic [11:0] o,
                     input logic [11:0] ei, input logic [11:0] eo);
    @(posedge clk) #1 dbl = d;
    iv = i;
    ov = o;
    ev = 1'b1;
    @(posedge clk) #1 ev = 1'b0;
    check("egress", {7'h0, evo, io, oo}, {7'h0, 1'b1, ei, eo});
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    rdc(16'h1834, w(11'h020, 11'h155));
    rdc(16'h1840, w(11'h080, 11'h009));
    rdc(16'h1844, w(11'h010, 11'h000));
    rdc(16'h1848, 32'h0);
    rdc(16'h1900, 32'h0);
    rdc(16'h1904, 32'h0);
    wrr(16'h1903, 4'h8, 32'h2);
    rdc(16'h1900, 32'h2);
    wrr(16'h1840, 4'hf, w(11'h123, 11'h045));
    rdc(16'h1840, w(11'h123, 11'h045));
    rdc(16'h1844, w(11'h010, 11'h222));
    wrr(16'h1834, 4'hf, 32'hffffffff);
    rdc(16'h1834, w(11'h7ff, 11'h155));
    wrr(16'h1900, 4'hf, 32'h0);
    rdc(16'h1840, w(11'h080, 11'h009));
    wrr(16'h2840, 4'hf, w(11'h001, 11'h001));
    rdc(16'h1840, w(11'h080, 11'h009));
    rdc(16'h2840, 32'h0);
    rdc(16'h1850, 32'h0);
  endtask

  task automatic t_drop;
    wrr(16'h1840, 4'hf, w(11'h010, 11'h008));
    wrr(16'h1844, 4'hf, w(11'h7ff, 11'h000));
    pol = 1'b1;
    for (int i = 0; i < 12; i++) begin
      av0 = (i == 9) ? 11'h004 : (i == 10) ? 11'h00c : 11'h020;
      wrr(16'h1848, 4'hf, {tm[i], 24'h0});
      judge(tc[2*i +: 2], te[i]);
    end
    // last packet is counted one edge after its verdict, policing still on
    @(posedge clk) #1 pol = 1'b0;
    judge(2'h0, 1'b0);
    // not counted: policing off
    for (int t = 0; t < 4; t++) begin
      ty = t[1:0];
      repeat (2) @(posedge clk);
      rdc(16'h1848, {8'h84, 24'(6 - t)});
    end
    wrr(16'h1848, 4'hf, 32'hc4000000);
    repeat (3) @(posedge clk);
    #1;
    for (int t = 0; t < 4; t++) begin
      ty = t[1:0];
      repeat (2) @(posedge clk);
      rdc(16'h1848, 32'hc4000000);
    end
  endtask

  task automatic t_vid;
    egr(1'b0, 12'h123, 12'h456, 12'h123, 12'h456);
    wrr(16'h1904, 4'hf, 32'h1);
    rdc(16'h1904, 32'h1);
    egr(1'b0, 12'h123, 12'h456, 12'h5a5, 12'h456);
    egr(1'b0, 12'h000, 12'h456, 12'h000, 12'h456);
    egr(1'b1, 12'h123, 12'h456, 12'h123, 12'h5a5);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (4) @(posedge clk);
    t_regs;
    t_drop;
    t_vid;
    stop_test;
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    stop_test;
  end
endmodule
`default_nettype wire
